//--- rtl/mgmt_slave.v
`timescale 1ns/1ps
`default_nettype none
`include "mgmt_slave_regs.vh"

module mgmt_slave (
   input wire REF_CLK,
   input wire RST,
   input wire MDC,
   input wire MDIO_I,
   output reg MDIO_O,
   output reg MDIO_OE,
   input wire [2:0] unique_address_strap,
   input wire broadcast_disable_strap
);

   localparam ST_PRE = 3'h0;
   localparam ST_ST = 3'h1;
   localparam ST_OP = 3'h2;
   localparam ST_ADR = 3'h3;
   localparam ST_TA = 3'h4;
   localparam ST_DAT = 3'h5;
   localparam ST_SKIP = 3'h6;

   reg mdc_s1_reg;
   reg mdc_s2_reg;
   reg mdc_s3_reg;
   reg dat_s1_reg;
   reg dat_s2_reg;
   reg [2:0] adr_s1_reg;
   reg [2:0] adr_s2_reg;
   reg bc_s1_reg;
   reg bc_s2_reg;
   reg [2:0] strap_adr_reg;
   reg strap_bc_reg;
   reg [2:0] state_reg;
   reg [5:0] cnt_reg;
   reg [1:0] op_reg;
   reg [9:0] adr_reg;
   reg [15:0] sh_reg;
   reg hit_reg;
   reg wr_en_reg;
   reg [4:0] wr_adr_reg;
   reg [15:0] wr_dat_reg;
   reg [`MS_REG_W-1:0] regs [0:`MS_NUM_REGS-1];
   integer i;

   wire rise = mdc_s2_reg & ~mdc_s3_reg;
   wire bit_in = dat_s2_reg;
   wire [4:0] phy_adr = adr_reg[9:5];
   wire [4:0] reg_adr = adr_reg[4:0];
   wire [15:0] ctrl_val = regs[`MS_CTRL_REG];
   wire bc_on = ~strap_bc_reg & ~ctrl_val[`MS_BCAST_OFF_BIT];
   wire adr_match = (phy_adr == {2'h0, strap_adr_reg}) ||
                    (bc_on && phy_adr == `MS_BCAST_ADDR);

   // Pin synchronisers
   always @(posedge REF_CLK) begin
      mdc_s1_reg <= MDC;
      mdc_s2_reg <= mdc_s1_reg;
      mdc_s3_reg <= mdc_s2_reg;
      dat_s1_reg <= MDIO_I;
      dat_s2_reg <= dat_s1_reg;
   end

   // Strap synchronisers
   always @(posedge REF_CLK) begin
      adr_s1_reg <= unique_address_strap;
      adr_s2_reg <= adr_s1_reg;
      bc_s1_reg <= broadcast_disable_strap;
      bc_s2_reg <= bc_s1_reg;
   end

   // Straps caught while reset is held
   always @(posedge REF_CLK) begin
      if (RST) begin
         strap_adr_reg <= adr_s2_reg;
         strap_bc_reg <= bc_s2_reg;
      end
   end

   // Register file, written the cycle after a write frame ends
   always @(posedge REF_CLK) begin
      if (RST) begin
         for (i = 0; i < `MS_NUM_REGS; i = i + 1) begin
            regs[i] <= `MS_REG_RESET;
         end
      end else if (wr_en_reg) begin
         regs[wr_adr_reg] <= wr_dat_reg;
      end
   end

   // Frame decoder
   always @(posedge REF_CLK) begin
      wr_en_reg <= 1'b0;
      if (RST) begin
         state_reg <= ST_PRE;
         cnt_reg <= 6'h00;
         op_reg <= 2'h0;
         adr_reg <= 10'h000;
         sh_reg <= 16'h0000;
         hit_reg <= 1'b0;
         MDIO_O <= 1'b0;
         MDIO_OE <= 1'b0;
         wr_adr_reg <= 5'h00;
         wr_dat_reg <= 16'h0000;
      end else if (rise) begin
         case (state_reg)
            // Preamble hunt
            ST_PRE: begin
               if (bit_in) begin
                  if (cnt_reg != `MS_PREAMBLE_LEN) begin
                     cnt_reg <= cnt_reg + 6'h01;
                  end
               end else if (cnt_reg == `MS_PREAMBLE_LEN) begin
                  state_reg <= ST_ST;
               end else begin
                  cnt_reg <= 6'h00;
               end
            end

            // Second start bit
            ST_ST: begin
               cnt_reg <= 6'h00;
               if (bit_in) begin
                  state_reg <= ST_OP;
               end else begin
                  state_reg <= ST_PRE;
               end
            end

            // Opcode
            ST_OP: begin
               op_reg <= {op_reg[0], bit_in};
               if (cnt_reg == `MS_OP_LAST) begin
                  cnt_reg <= 6'h00;
                  if ({op_reg[0], bit_in} == `MS_OP_READ ||
                      {op_reg[0], bit_in} == `MS_OP_WRITE) begin
                     state_reg <= ST_ADR;
                  end else begin
                     state_reg <= ST_PRE;
                  end
               end else begin
                  cnt_reg <= cnt_reg + 6'h01;
               end
            end

            // Device and register addresses
            ST_ADR: begin
               adr_reg <= {adr_reg[8:0], bit_in};
               if (cnt_reg == `MS_ADR_LAST) begin
                  cnt_reg <= 6'h00;
                  state_reg <= ST_TA;
               end else begin
                  cnt_reg <= cnt_reg + 6'h01;
               end
            end

            // Turnaround
            ST_TA: begin
               if (cnt_reg == 6'h00) begin
                  hit_reg <= adr_match;
                  cnt_reg <= 6'h01;
                  if (op_reg == `MS_OP_READ && adr_match) begin
                     MDIO_OE <= 1'b1;
                     MDIO_O <= 1'b0;
                     sh_reg <= regs[reg_adr];
                  end
               end else begin
                  cnt_reg <= 6'h00;
                  state_reg <= ST_DAT;
                  if (MDIO_OE) begin
                     MDIO_O <= sh_reg[15];
                     sh_reg <= {sh_reg[14:0], 1'b0};
                  end
               end
            end

            // Data bits
            ST_DAT: begin
               if (op_reg == `MS_OP_WRITE) begin
                  sh_reg <= {sh_reg[14:0], bit_in};
               end else if (MDIO_OE) begin
                  MDIO_O <= sh_reg[15];
                  sh_reg <= {sh_reg[14:0], 1'b0};
               end
               if (cnt_reg == `MS_DAT_LAST) begin
                  cnt_reg <= 6'h00;
                  state_reg <= ST_PRE;
                  MDIO_OE <= 1'b0;
                  MDIO_O <= 1'b0;
                  if (op_reg == `MS_OP_WRITE && hit_reg) begin
                     wr_en_reg <= 1'b1;
                     wr_adr_reg <= reg_adr;
                     wr_dat_reg <= {sh_reg[14:0], bit_in};
                  end
               end else begin
                  cnt_reg <= cnt_reg + 6'h01;
               end
            end

            // Unused codes fall back to the hunt
            default: begin
               state_reg <= ST_PRE;
               cnt_reg <= 6'h00;
               hit_reg <= 1'b0;
               MDIO_OE <= 1'b0;
               MDIO_O <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

//--- rtl/mgmt_slave_regs.vh
`ifndef MGMT_SLAVE_REGS_VH
`define MGMT_SLAVE_REGS_VH

// Frame field codes
`define MS_START_CODE 2'h1
`define MS_OP_READ 2'h2
`define MS_OP_WRITE 2'h1
`define MS_PREAMBLE_LEN 6'h20
`define MS_OP_LAST 6'h01
`define MS_ADR_LAST 6'h09
`define MS_DAT_LAST 6'h0f
`define MS_BCAST_ADDR 5'h00

// Register file layout
`define MS_NUM_REGS 32
`define MS_REG_W 16
`define MS_STD_LAST 5'h08
`define MS_CTRL_REG 5'h16
`define MS_BCAST_OFF_BIT 9

// Reset values
`define MS_REG_RESET 16'h0000

`endif

//--- tb/mgmt_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctl_model (
   output logic MDC,
   output logic ctl_o,
   output logic ctl_oe,
   input wire logic line
);
   initial begin
      MDC = 1'b0;
      ctl_o = 1'b1;
      ctl_oe = 1'b0;
   end
   // MDC stands low between frames
   task automatic xfer(input logic [3:0] h, input logic [9:0] a, input logic [15:0] d,
      output logic [63:0] s);
      logic [63:0] f;
      f = {32'hffffffff, h, a, (h == 4'h6) ? 2'h3 : 2'h2, d};
      for (int i = 63; i >= 0; i--) begin
         ctl_oe = (h != 4'h6) || (i > 17);
         ctl_o = f[i];
         #62.5 MDC = 1'b1;
         s[i] = line;
         #62.5 MDC = 1'b0;
      end
      ctl_oe = 1'b0;
   endtask
endmodule
`default_nettype wire

//--- tb/mgmt_slave_props.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_slave_props (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic MDC,
   input wire logic MDIO_O,
   input wire logic MDIO_OE
);
   logic m1, m2, m3;
   logic [3:0] sr;
   logic [9:0] hi, lo;
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   sequence ta_zero; !MDIO_O [*8]; endsequence
   // Cycles since MDC rose, and driver on and off spans
   always @(posedge REF_CLK) begin
      m1 <= MDC;
      m2 <= m1;
      m3 <= m2;
      sr <= (m2 && !m3) ? 4'h0 : sr + {3'h0, sr != 4'hf};
      hi <= MDIO_OE ? hi + 10'h1 : 10'h0;
      lo <= (RST || MDIO_OE) ? 10'h0 : lo + {9'h0, lo != 10'h3ff};
   end
   AST_RST: assert property (disable iff (1'b0) RST |=> !MDIO_OE) else $error("oe");
   AST_TA: assert property ($rose(MDIO_OE) |-> ta_zero) else $error("ta");
   AST_SPAN: assert property ($fell(MDIO_OE) |-> hi inside {[10'hcd:10'hdc]}) else $error("s");
   AST_MAX: assert property (hi <= 10'hdc) else $error("long");
   AST_GAP: assert property ($rose(MDIO_OE) |-> lo > 10'h1f4) else $error("gap");
   AST_ON: assert property ($rose(MDIO_OE) |-> sr <= 4'h6) else $error("on");
   AST_BIT: assert property (MDIO_OE && $changed(MDIO_O) |-> sr <= 4'h6) else $error("b");
   AST_OFF: assert property ($fell(MDIO_OE) |-> sr <= 4'h7) else $error("off");
endmodule
bind mgmt_slave mgmt_slave_props i_props (.REF_CLK(REF_CLK), .RST(RST), .MDC(MDC),
   .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE));
`default_nettype wire

//--- tb/mgmt_slave_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module mgmt_slave_tb_top;
   logic REF_CLK = 1'b0;
   logic RST = 1'b1;
   logic bdis = 1'b0;
   logic [2:0] uas = 3'h5;
   logic [63:0] s;
   wire logic MDC, co, coe, MDIO_O, MDIO_OE;
   // Pulled-up shared line
   wire logic line = MDIO_OE ? MDIO_O : (coe ? co : 1'b1);
   int n_fail = 0;
   int check_count = 0;
   int cyc = 0;
   mgmt_slave i_mgmt_slave (.REF_CLK(REF_CLK), .RST(RST), .MDC(MDC), .MDIO_I(line),
      .MDIO_O(MDIO_O), .MDIO_OE(MDIO_OE), .unique_address_strap(uas),
      .broadcast_disable_strap(bdis));
   mgmt_ctl_model i_ctl (.MDC(MDC), .ctl_o(co), .ctl_oe(coe), .line(line));
   initial forever #5 REF_CLK = ~REF_CLK;
   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic rst(input logic [2:0] u, input logic b);
      @(posedge REF_CLK);
      RST <= 1'b1;
      uas <= u;
      bdis <= b;
      repeat (5) @(posedge REF_CLK);
      RST <= 1'b0;
      repeat (4) @(posedge REF_CLK);
   endtask
   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [4:0] p, input logic [4:0] r, input logic h, input logic [15:0] d);
      i_ctl.xfer(4'h6, {p, r}, 16'h0, s);
      check(s[17:0], h ? {2'h2, d} : 18'h3ffff);
   endtask
   task automatic t_own;
      rst(3'h5, 1'b0);
      rd(5'h05, 5'h08, 1'b1, 16'h0);
      i_ctl.xfer(4'h5, 10'h0a3, 16'ha5c3, s);
      i_ctl.xfer(4'h5, 10'h0bf, 16'h3c5a, s);
      rd(5'h05, 5'h03, 1'b1, 16'ha5c3);
      rd(5'h05, 5'h1f, 1'b1, 16'h3c5a);
      $display("own done");
   endtask
   task automatic t_miss;
      i_ctl.xfer(4'h5, 10'h0c3, 16'hffff, s);
      i_ctl.xfer(4'h5, 10'h1a3, 16'h1111, s);
      i_ctl.xfer(4'h1, 10'h0a3, 16'h2222, s);
      i_ctl.xfer(4'h7, 10'h0a3, 16'h3333, s);
      i_ctl.xfer(4'h4, 10'h0a3, 16'h4444, s);
      rd(5'h06, 5'h03, 1'b0, 16'h0);
      rd(5'h05, 5'h03, 1'b1, 16'ha5c3);
      $display("refused done");
   endtask
   task automatic t_bc;
      rd(5'h00, 5'h03, 1'b1, 16'ha5c3);
      i_ctl.xfer(4'h5, 10'h016, 16'h0200, s);
      rd(5'h00, 5'h03, 1'b0, 16'h0);
      rd(5'h05, 5'h16, 1'b1, 16'h0200);
      rst(3'h2, 1'b1);
      rd(5'h00, 5'h03, 1'b0, 16'h0);
      rst(3'h0, 1'b1);
      rd(5'h00, 5'h16, 1'b1, 16'h0);
      $display("broadcast done");
   endtask
   initial begin
      t_own();
      t_miss();
      t_bc();
      test_done();
   end
endmodule
`default_nettype wire
